//--- design/injector_ctrl.sv
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module injector_ctrl
    import inj_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            arst_n,
    input  wire logic [AW-1:0]   addr,
    input  wire logic [DW-1:0]   wdata,
    input  wire logic            wr,
    input  wire logic            rd,
    output logic      [DW-1:0]   rdata,
    input  wire logic [NCH-1:0]  inj_cmd,
    input  wire logic [NCH-1:0]  at_peak,
    input  wire logic [NCH-1:0]  at_hold,
    input  wire logic [NCH-1:0]  fast_rise,
    input  wire logic [NCH-1:0]  over_cur,
    output logic      [NCH-1:0]  drive,
    output logic      [NCH-1:0]  peak_sel,
    output logic      [NCH-1:0]  regulate,
    output logic                 irq
);

    typedef enum logic [1:0] {
        IDLE,
        PEAK,
        HOLD
    } ch_state_t;

    typedef struct packed {
        ch_state_t [NCH-1:0]            st;
        logic      [NCH-1:0][PT_W-1:0]  peak_req;
        logic      [NCH-1:0][PT_W-1:0]  peak_used;
        logic      [NCH-1:0][PT_W-1:0]  peak_cnt;
        logic      [NCH-1:0][WIN_W-1:0] win_cnt;
        logic      [NCH-1:0]            reached;
        logic      [NCH-1:0]            hold_seen;
        logic      [NCH-1:0]            open_flag;
        logic      [NCH-1:0]            short_flag;
        logic      [IRQ_W-1:0]          status;
        logic      [IRQ_W-1:0]          mask;
        logic      [DW-1:0]             rdata;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;
    logic        us_tick;
    logic        take_tick;

    // ****************************************
    // Time base
    // ****************************************
    tick_gen u_tick (
        .clock     (clock),
        .arst_n    (arst_n),
        .us_tick   (us_tick),
        .take_tick (take_tick)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic [NCH-1:0]   act;
        logic [NCH-1:0]   hold_ph;
        logic             early;
        logic             shorted;
        ev      = '0;
        act     = '0;
        hold_ph = '0;
        early   = 1'b0;
        shorted = 1'b0;
        next_s  = s;

        // Register writes
        if (wr) begin
            if (addr < A_FLAGS) begin
                next_s.peak_req[addr[1:0]] = wdata;
            end
            if (addr == A_FLAGS) begin
                for (int i = 0; i < NCH; i++) begin
                    if (wdata[F_OPEN + i]) begin
                        next_s.open_flag[i] = 1'b0;
                    end
                    // Clear refused mid-command so a live short stays latched
                    if (wdata[F_SHORT + i] && !inj_cmd[i]) begin
                        next_s.short_flag[i] = 1'b0;
                    end
                end
            end
            if (addr == A_MASK) begin
                next_s.mask = wdata[IRQ_W-1:0];
            end
        end

        // Peak time only moves on the takeup tick
        if (take_tick) begin
            next_s.peak_used = s.peak_req;
        end

        // Channels, all alike and independent
        for (int i = 0; i < NCH; i++) begin
            early   = s.win_cnt[i] < WIN_LEN;
            shorted = early ? fast_rise[i] : over_cur[i];
            act[i]     = s.st[i] != IDLE;
            hold_ph[i] = s.st[i] == HOLD;
            case (s.st[i])
                IDLE: begin
                    if (inj_cmd[i] && !s.short_flag[i]) begin
                        next_s.st[i]        = (s.peak_used[i] == PT_ZERO) ? HOLD : PEAK;
                        next_s.peak_cnt[i]  = PT_ZERO;
                        next_s.win_cnt[i]   = '0;
                        next_s.reached[i]   = 1'b0;
                        next_s.hold_seen[i] = 1'b0;
                    end
                end
                PEAK, HOLD: begin
                    if (at_peak[i] || at_hold[i]) begin
                        next_s.reached[i] = 1'b1;
                    end
                    if (at_hold[i]) begin
                        next_s.hold_seen[i] = 1'b1;
                    end
                    if (us_tick && early) begin
                        next_s.win_cnt[i] = s.win_cnt[i] + WIN_ONE;
                    end
                    if (!inj_cmd[i]) begin
                        next_s.st[i] = IDLE;
                        if (!(s.reached[i] || at_peak[i] || at_hold[i])) begin
                            next_s.open_flag[i] = 1'b1;
                            ev[F_OPEN + i]      = 1'b1;
                        end
                    end else if (shorted) begin
                        // Early: rise rate; later: overcurrent
                        next_s.st[i]         = IDLE;
                        next_s.short_flag[i] = 1'b1;
                        ev[F_SHORT + i]      = 1'b1;
                    end else if (s.st[i] == PEAK) begin
                        if (s.peak_cnt[i] >= s.peak_used[i]) begin
                            next_s.st[i] = HOLD;
                        end else if (us_tick) begin
                            next_s.peak_cnt[i] = s.peak_cnt[i] + PT_ONE;
                        end
                    end
                end
                default: begin
                    next_s.st[i] = IDLE;
                end
            endcase
        end

        // Read data, one cycle after the strobe
        next_s.rdata = RD_ZERO;
        if (rd) begin
            if (addr < A_FLAGS) begin
                next_s.rdata = s.peak_req[addr[1:0]];
            end else if (addr == A_FLAGS) begin
                next_s.rdata = {hold_ph, act, s.short_flag, s.open_flag};
            end else if (addr == A_STATUS) begin
                next_s.rdata = {PAD8, s.status};
                next_s.status = '0;
            end else if (addr == A_MASK) begin
                next_s.rdata = {PAD8, s.mask};
            end
        end

        // Set beats the read clear
        next_s.status = next_s.status | ev;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    for (genvar g = 0; g < NCH; g++) begin : g_out
        assign drive[g]    = s.st[g] != IDLE;
        assign peak_sel[g] = s.st[g] == PEAK;
        // Regulated in peak; in hold, full on until hold current is first seen
        assign regulate[g] = (s.st[g] == PEAK) || (s.st[g] == HOLD && s.hold_seen[g]);
    end

    assign rdata = s.rdata;
    assign irq   = |(s.status & s.mask);

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // Helper terms for the checks below
    logic shorted_0;
    logic ev_none;
    assign shorted_0 = (s.win_cnt[0] < WIN_LEN) ? fast_rise[0] : over_cur[0];
    // All idle, so no event can refill status at the read edge
    assign ev_none   = ~|(next_s.status & ~s.status) && ~|(s.st);

    property p_start;
        (s.st[0] == IDLE && inj_cmd[0] && !s.short_flag[0]) |=> drive[0];
    endproperty
    a_start: assert property (p_start) else $error("Enabled command did not start event");

    property p_peak_first;
        (s.st[0] == IDLE && inj_cmd[0] && !s.short_flag[0] && s.peak_used[0] != PT_ZERO)
            |=> peak_sel[0];
    endproperty
    a_peak_first: assert property (p_peak_first) else $error("Event did not open at peak");

    property p_fold;
        (s.st[0] == PEAK && inj_cmd[0] && !shorted_0 && s.peak_cnt[0] >= s.peak_used[0])
            |=> (s.st[0] == HOLD && !peak_sel[0] && drive[0]);
    endproperty
    a_fold: assert property (p_fold) else $error("Peak did not fold back to hold");

    property p_takeup;
        take_tick |=> (s.peak_used == $past(s.peak_req));
    endproperty
    a_takeup: assert property (p_takeup) else $error("Peak time not taken up on tick");

    property p_open;
        (drive[0] && !inj_cmd[0] && !s.reached[0] && !at_peak[0] && !at_hold[0])
            |=> (s.open_flag[0] && s.status[F_OPEN] && !drive[0]);
    endproperty
    a_open: assert property (p_open) else $error("Open flag missed at event end");

    property p_short_early;
        (drive[0] && inj_cmd[0] && s.win_cnt[0] < WIN_LEN && fast_rise[0])
            |=> (s.short_flag[0] && !drive[0]);
    endproperty
    a_short_early: assert property (p_short_early) else $error("Fast rise not flagged");

    property p_short_late;
        (drive[0] && inj_cmd[0] && s.win_cnt[0] >= WIN_LEN && over_cur[0])
            |=> (s.short_flag[0] && s.status[F_SHORT]);
    endproperty
    a_short_late: assert property (p_short_late) else $error("Late short not flagged");

    property p_disabled;
        s.short_flag[0] |-> !drive[0];
    endproperty
    a_disabled: assert property (p_disabled) else $error("Shorted channel driven");

    property p_noclear;
        (s.short_flag[0] && inj_cmd[0]) |=> s.short_flag[0];
    endproperty
    a_noclear: assert property (p_noclear) else $error("Short flag cleared under command");

    property p_hold_reg;
        (s.st[0] == HOLD && !s.hold_seen[0]) |-> !regulate[0];
    endproperty
    a_hold_reg: assert property (p_hold_reg) else $error("Regulating before hold reached");

    property p_irq;
        (rd && addr == A_STATUS && ev_none) |=> !irq;
    endproperty
    a_irq: assert property (p_irq) else $error("Status read did not clear interrupt");

    // ****************************************
    // Further checks on channel 0, channel 1, the takeup tick and the bus
    // ****************************************
    property p_rd_zero;
        !rd |=> (rdata == RD_ZERO);
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("Read data not zero outside read");

    property p_read_clear;
        (rd && addr == A_STATUS && s.st[0] == IDLE) |=> !s.status[F_OPEN];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("Status read left open bit set");

    property p_status_keep;
        (s.status[F_OPEN] && !(rd && addr == A_STATUS)) |=> s.status[F_OPEN];
    endproperty
    a_status_keep: assert property (p_status_keep) else $error("Open status bit lost without read");

    property p_open_keep;
        (s.open_flag[0] && !(wr && addr == A_FLAGS && wdata[F_OPEN])) |=> s.open_flag[0];
    endproperty
    a_open_keep: assert property (p_open_keep) else $error("Open flag lost without clear");

    property p_short_keep;
        (s.short_flag[0] && !(wr && addr == A_FLAGS && wdata[F_SHORT])) |=> s.short_flag[0];
    endproperty
    a_short_keep: assert property (p_short_keep) else $error("Short flag lost without clear");

    property p_end;
        (drive[0] && !inj_cmd[0]) |=> !drive[0];
    endproperty
    a_end: assert property (p_end) else $error("Event did not end with command");

    property p_zero_peak;
        (s.st[0] == IDLE && inj_cmd[0] && !s.short_flag[0] && s.peak_used[0] == PT_ZERO)
            |=> (drive[0] && !peak_sel[0]);
    endproperty
    a_zero_peak: assert property (p_zero_peak) else $error("Zero peak time still opened at peak");

    property p_peak_stay;
        (s.st[0] == PEAK && inj_cmd[0] && !shorted_0 && s.peak_cnt[0] < s.peak_used[0]) |=> peak_sel[0];
    endproperty
    a_peak_stay: assert property (p_peak_stay) else $error("Peak left before peak time");

    property p_hold_stay;
        (s.st[0] == HOLD && inj_cmd[0] && !shorted_0) |=> (drive[0] && !peak_sel[0]);
    endproperty
    a_hold_stay: assert property (p_hold_stay) else $error("Hold left while commanded");

    property p_reg_on;
        (s.st[0] == HOLD && at_hold[0] && inj_cmd[0] && !shorted_0) |=> regulate[0];
    endproperty
    a_reg_on: assert property (p_reg_on) else $error("Hold current seen but not regulated");

    property p_late_only;
        (drive[0] && inj_cmd[0] && s.win_cnt[0] >= WIN_LEN && !over_cur[0]) |=> drive[0];
    endproperty
    a_late_only: assert property (p_late_only) else $error("Late event stopped without overcurrent");

    property p_take_only;
        !take_tick |=> $stable(s.peak_used);
    endproperty
    a_take_only: assert property (p_take_only) else $error("Peak time moved between ticks");

    property p_start_ch1;
        (s.st[1] == IDLE && inj_cmd[1] && !s.short_flag[1]) |=> drive[1];
    endproperty
    a_start_ch1: assert property (p_start_ch1) else $error("Second channel did not start");

    c_full_event: cover property (peak_sel[0] ##[1:1000] (s.st[0] == HOLD) ##[1:1000] !drive[0]);
    c_zero_peak:  cover property ((s.st[0] == IDLE) ##1 (s.st[0] == HOLD));
    c_short:      cover property ($rose(s.short_flag[0]));
    c_open:       cover property ($rose(s.open_flag[0]));
    c_irq:        cover property ($rose(irq));

endmodule // injector_ctrl

//--- design/inj_pkg.sv
package inj_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NCH   = 4;
    localparam int DW    = 16;
    localparam int AW    = 4;
    localparam int PT_W  = 16;
    localparam int WIN_W = 8;
    localparam int IRQ_W = 2 * NCH;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int US_NS         = 1000;
    localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
    localparam int TAKEUP_US     = 125;
    localparam int SHORT_WIN_US  = 20;
    localparam int CYC_W         = 5;
    localparam int US_W          = 7;
    localparam logic [CYC_W-1:0] CYC_LAST  = CYC_W'(CYC_PER_US - 1);
    localparam logic [US_W-1:0]  TAKE_LAST = US_W'(TAKEUP_US - 1);
    localparam logic [WIN_W-1:0] WIN_LEN   = WIN_W'(SHORT_WIN_US);
    localparam logic [WIN_W-1:0] WIN_ONE   = 8'h01;
    localparam logic [PT_W-1:0]  PT_ONE    = 16'h0001;
    localparam logic [PT_W-1:0]  PT_ZERO   = 16'h0000;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [AW-1:0] A_PEAK0  = 4'h0;
    localparam logic [AW-1:0] A_FLAGS  = 4'h4;
    localparam logic [AW-1:0] A_STATUS = 4'h5;
    localparam logic [AW-1:0] A_MASK   = 4'h6;
    localparam int F_OPEN  = 0;
    localparam int F_SHORT = 4;
    localparam int F_ACT   = 8;
    localparam int F_HOLD  = 12;
    localparam logic [DW-1:0]    RD_ZERO   = 16'h0000;
    localparam logic [IRQ_W-1:0] MASK_RST  = 8'h00;
    localparam logic [7:0]       PAD8      = 8'h00;

endpackage

//--- design/tick_gen.sv
`timescale 1ns/1ps
module tick_gen
    import inj_pkg::*;
(
    input  wire logic clock,
    input  wire logic arst_n,
    output logic      us_tick,
    output logic      take_tick
);

    typedef struct packed {
        logic [CYC_W-1:0] cyc;
        logic [US_W-1:0]  us;
        logic             us_tick;
        logic             take_tick;
    } tick_state_t;

    tick_state_t s;
    tick_state_t next_s;

    // ****************************************
    // Divider chain
    // ****************************************
    always_comb begin
        next_s           = s;
        next_s.us_tick   = 1'b0;
        next_s.take_tick = 1'b0;
        if (s.cyc == CYC_LAST) begin
            next_s.cyc     = '0;
            next_s.us_tick = 1'b1;
            if (s.us == TAKE_LAST) begin
                next_s.us        = '0;
                next_s.take_tick = 1'b1;
            end else begin
                next_s.us = s.us + 7'h01;
            end
        end else begin
            next_s.cyc = s.cyc + 5'h01;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign us_tick   = s.us_tick;
    assign take_tick = s.take_tick;

endmodule // tick_gen

//--- testbench/load_model.sv
`timescale 1ns/1ps
module load_model
    import inj_pkg::*;
(
    input  wire logic [0:0]       clock,
    input  wire logic [NCH-1:0]   drive,
    input  wire logic [NCH-1:0]   peak_sel,
    input  wire logic [2*NCH-1:0] mode,
    output logic      [NCH-1:0]   at_peak,
    output logic      [NCH-1:0]   at_hold,
    output logic      [NCH-1:0]   fast_rise,
    output logic      [NCH-1:0]   over_cur
);
    // ****************************************
    // Solenoid current per channel
    // ****************************************
    // Mode: 0 good, 1 open, 2 early short, 3 late short
    int cnt [NCH];

    // Current collapses as soon as the switch opens
    always_ff @(posedge clock) begin
        for (int i = 0; i < NCH; i++) begin
            cnt[i] <= drive[i] ? cnt[i] + 1 : 0;
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            at_hold[i]   = drive[i] && cnt[i] >= 3 && mode[2*i+:2] != 2'h1;
            at_peak[i]   = at_hold[i] && peak_sel[i] && cnt[i] >= 8;
            fast_rise[i] = drive[i] && mode[2*i+:2] == 2'h2;
            over_cur[i]  = drive[i] && mode[2*i+:2] == 2'h3 && cnt[i] >= 600;
        end
    end
endmodule // load_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import inj_pkg::*;
    logic              clock;
    logic              arst_n;
    logic [AW-1:0]     addr;
    logic [DW-1:0]     wdata;
    logic              wr;
    logic              rd;
    logic [DW-1:0]     rdata;
    logic [NCH-1:0]    inj_cmd;
    logic [NCH-1:0]    at_peak;
    logic [NCH-1:0]    at_hold;
    logic [NCH-1:0]    fast_rise;
    logic [NCH-1:0]    over_cur;
    logic [NCH-1:0]    drive;
    logic [NCH-1:0]    peak_sel;
    logic [NCH-1:0]    regulate;
    logic              irq;
    logic [2*NCH-1:0]  mode;
    logic [PT_W-1:0]   pt [NCH];
    int                seed;
    int                cyc;
    int                n;
    int                mismatches;
    int                tests_run;

    injector_ctrl u_dut (.clock, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .inj_cmd, .at_peak,
        .at_hold, .fast_rise, .over_cur, .drive, .peak_sel, .regulate, .irq);
    load_model u_load (.clock, .drive, .peak_sel, .mode, .at_peak, .at_hold, .fast_rise, .over_cur);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Cycles since release, to place events against the takeup tick
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cyc <= 0;
        end else begin
            cyc <= cyc + 1;
        end
    end

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] s);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %0h", a), e, rdata);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 22;
        mismatches = 0;
        tests_run = 0;
        arst_n = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        inj_cmd = 4'h0;
        mode = 8'h00;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        #1;
        chk("outputs", 16'h0000, {drive, peak_sel, regulate, 3'h0, irq});
        for (int a = 0; a < 16; a++) begin
            rchk(AW'(a), RD_ZERO);
        end
        wreg(4'hA, 16'hFFFF);
        wreg(A_STATUS, 16'h00FF);
        rchk(4'hA, RD_ZERO);
        rchk(A_STATUS, RD_ZERO);
        $display("test reset done");

        for (int i = 0; i < NCH; i++) begin
            pt[i] = PT_W'(3 + ($random(seed) & 7));
            wreg(A_PEAK0 + AW'(i), pt[i]);
        end
        wreg(A_MASK, 16'h00FF);
        for (int i = 0; i < NCH; i++) begin
            rchk(A_PEAK0 + AW'(i), pt[i]);
        end
        rchk(A_MASK, 16'h00FF);
        $display("test registers done");

        // Good, open, early short and late short side by side
        while (cyc < 2600) @(posedge clock);
        mode <= 8'hE4;
        inj_cmd <= 4'hF;
        @(posedge clock);
        #1;
        chk("start", 16'h0007, {13'h0, drive[0], peak_sel[0], regulate[0]});
        n = 0;
        while (peak_sel[0] === 1'b1 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("peak len", 16'h0001, 16'(n >= (pt[0] - 1) * CYC_PER_US && n <= pt[0] * CYC_PER_US + 2));
        chk("early short", 16'h0000, 16'(drive[2]));
        n = 0;
        while (drive[3] === 1'b1 && n < 1000) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("late short", 16'h0001, 16'(n > 300 && n < 1000));
        chk("hold", 16'h0003, 16'({peak_sel[0], regulate[1], regulate[0], drive[0]}));
        @(posedge clock);
        inj_cmd <= 4'h4;
        @(posedge clock);
        #1;
        chk("end", 16'h0000, 16'(drive));
        chk("irq set", 16'h0001, 16'(irq));
        rchk(A_FLAGS, 16'h00C2);
        rchk(A_STATUS, 16'h00C2);
        @(posedge clock);
        #1;
        chk("irq clear", 16'h0000, 16'(irq));
        rchk(A_STATUS, RD_ZERO);
        wreg(A_FLAGS, 16'h00C0);
        rchk(A_FLAGS, 16'h0042);
        chk("held off", 16'h0000, 16'(drive[2]));
        @(posedge clock);
        inj_cmd <= 4'h0;
        // One clear only: a real short would be re-armed by repeats
        wreg(A_FLAGS, 16'h00FF);
        rchk(A_FLAGS, RD_ZERO);
        $display("test channels done");

        // Peak time zero for a high resistance load
        while (cyc % 2500 != 200) @(posedge clock);
        wreg(A_PEAK0, PT_ZERO);
        wreg(A_PEAK0 + 4'h1, PT_ZERO);
        @(posedge clock);
        mode <= 8'h04;
        inj_cmd <= 4'h1;
        @(posedge clock);
        #1;
        chk("old peak", 16'h0001, 16'(peak_sel[0]));
        while (cyc % 2500 != 200) @(posedge clock);
        inj_cmd <= 4'h0;
        @(posedge clock);
        inj_cmd <= 4'h3;
        @(posedge clock);
        #1;
        chk("zero peak", 16'h0030, 16'({drive[1:0], peak_sel[1:0], regulate[1:0]}));
        repeat (10) @(posedge clock);
        #1;
        chk("hold reg", 16'h0001, 16'(regulate[1:0]));
        @(posedge clock);
        inj_cmd <= 4'h0;
        // Open on the high resistance channel is expected and ignored
        rchk(A_FLAGS, 16'h0002);
        $display("test peak time done");
        tally_and_finish();
    end
endmodule // tb
